// ==== hdl/dbf_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbf_filter #(
  parameter int NCH = dbf_pkg::NUM_CHANNELS
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire dbf_pkg::dbf_cfg_s cfg_i [NCH],
  input wire logic [NCH-1:0] din_i,
  output logic [NCH-1:0] dout_o,
  output logic [NCH-1:0] busy_o
);
  import dbf_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  // Only whole cycles per microsecond are handled; other clock rates drift

  // Clamp a zero setting to the least legal time
  // Zero is outside the legal range, so it is read as one microsecond
  function automatic logic [TIME_WIDTH-1:0] eff_time(input logic [TIME_WIDTH-1:0] t);
    eff_time = (t < TIME_MIN_US) ? TIME_MIN_US : t;
  endfunction

  logic [TW-1:0] tick_cnt_ff, nxt_tick_cnt;
  logic tick;

  // Free-running, so a hold may start anywhere inside a tick period
  // Microsecond tick divider
  always_comb begin
    tick = (tick_cnt_ff == TICK_LAST);
    nxt_tick_cnt = tick ? '0 : tick_cnt_ff + TW'(1);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end

  // Last cycle's sample; an edge is a difference from it
  logic [NCH-1:0] prev_ff, nxt_prev;
  logic [NCH-1:0] out_ff, nxt_out;
  logic [NCH-1:0] hold_ff, nxt_hold;
  logic [TIME_WIDTH-1:0] cnt_ff [NCH];
  logic [TIME_WIDTH-1:0] nxt_cnt [NCH];

  // Per-channel filter state; every channel is identical
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      logic rise;
      logic fall;
      logic done;
      rise = din_i[c] & ~prev_ff[c];
      fall = ~din_i[c] & prev_ff[c];
      // Expiry on the tick that brings the count to the set time
      done = hold_ff[c] && tick && (cnt_ff[c] + 16'h0001 >= eff_time(cfg_i[c].time_us));
      nxt_prev[c] = din_i[c];
      nxt_out[c] = out_ff[c];
      nxt_hold[c] = hold_ff[c];
      nxt_cnt[c] = cnt_ff[c];
      // Counts only on ticks, so a hold can lose up to one tick at its start
      if (hold_ff[c] && tick) begin
        nxt_cnt[c] = cnt_ff[c] + 16'h0001;
      end
      // A mode change mid-hold carries the hold on under the new mode, unless that mode is off or an undefined code, which clear it
      case (cfg_i[c].mode)
        DBF_OFF: begin
          nxt_out[c] = din_i[c];
          nxt_hold[c] = 1'b0;
          nxt_cnt[c] = CNT_RESET;
        end
        DBF_STR_RISE: begin
          // A new rising edge inside the hold restarts it
          if (rise) begin
            nxt_out[c] = 1'b1;
            nxt_hold[c] = 1'b1;
            nxt_cnt[c] = CNT_RESET;
          end else if (hold_ff[c] && !done) begin
            nxt_out[c] = 1'b1;
          end else begin
            nxt_out[c] = din_i[c];
            nxt_hold[c] = 1'b0;
          end
        end
        DBF_STR_FALL: begin
          // A new falling edge inside the hold restarts it
          if (fall) begin
            nxt_out[c] = 1'b0;
            nxt_hold[c] = 1'b1;
            nxt_cnt[c] = CNT_RESET;
          end else if (hold_ff[c] && !done) begin
            nxt_out[c] = 1'b0;
          end else begin
            nxt_out[c] = din_i[c];
            nxt_hold[c] = 1'b0;
          end
        end
        DBF_STR_BOTH: begin
          // Edges inside the hold are dropped; that is the debounce
          if (hold_ff[c] && !done) begin
            nxt_out[c] = out_ff[c];
          end else if (rise || fall) begin
            nxt_out[c] = din_i[c];
            nxt_hold[c] = 1'b1;
            nxt_cnt[c] = CNT_RESET;
          end else begin
            nxt_out[c] = din_i[c];
            nxt_hold[c] = 1'b0;
          end
        end
        DBF_DLY_BOTH: begin
          // Expiry takes the live level and detects no edge in that cycle
          if (hold_ff[c] && !done) begin
            nxt_out[c] = out_ff[c]; // Input blocked
          end else if (hold_ff[c]) begin
            nxt_out[c] = din_i[c]; // Take live level at expiry
            nxt_hold[c] = 1'b0;
          end else if (rise || fall) begin
            nxt_out[c] = din_i[c];
            nxt_hold[c] = 1'b1;
            nxt_cnt[c] = CNT_RESET;
          end else begin
            nxt_out[c] = din_i[c];
          end
        end
        default: begin
          // Undefined codes act as off so the channel never freezes
          nxt_out[c] = din_i[c];
          nxt_hold[c] = 1'b0;
          nxt_cnt[c] = CNT_RESET;
        end
      endcase
    end
  end

  // Reset clears counters and holds; output follows input afterwards
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_ff <= '0;
      out_ff <= '0;
      hold_ff <= '0;
      for (int c = 0; c < NCH; c++) begin
        cnt_ff[c] <= CNT_RESET;
      end
    end else begin
      prev_ff <= nxt_prev;
      out_ff <= nxt_out;
      hold_ff <= nxt_hold;
      for (int c = 0; c < NCH; c++) begin
        cnt_ff[c] <= nxt_cnt[c];
      end
    end
  end

  // Both outputs come straight from flip-flops
  assign dout_o = out_ff;
  assign busy_o = hold_ff;

  // Checks on channel 0; all channels share one body
  off_pass_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      cfg_i[0].mode == DBF_OFF && $stable(cfg_i[0].mode) |=> dout_o[0] == $past(din_i[0]))
    else $error("off mode output differs from input");
  rise_force_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      cfg_i[0].mode == DBF_STR_RISE && din_i[0] && !prev_ff[0] |=> dout_o[0] && busy_o[0])
    else $error("rising edge did not force high");
  fall_force_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      cfg_i[0].mode == DBF_STR_FALL && !din_i[0] && prev_ff[0] |=> !dout_o[0] && busy_o[0])
    else $error("falling edge did not force low");
  both_hold_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      cfg_i[0].mode == DBF_STR_BOTH && busy_o[0] && !tick && $stable(cfg_i[0].mode)
      |=> $stable(dout_o[0]))
    else $error("stretch both output moved during hold");
  dly_block_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      cfg_i[0].mode == DBF_DLY_BOTH && busy_o[0] && !tick |=> $stable(dout_o[0]))
    else $error("delay mode passed input during hold");
  dly_expire_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      cfg_i[0].mode == DBF_DLY_BOTH && busy_o[0] && tick
      && cnt_ff[0] + 16'h0001 >= eff_time(cfg_i[0].time_us)
      |=> !busy_o[0] && dout_o[0] == $past(din_i[0]))
    else $error("delay expiry did not take live input");
  // Nine quiet cycles between ticks at ten cycles per microsecond
  tick_rate_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      tick |=> !tick [*8] ##1 !tick ##1 tick)
    else $error("microsecond tick period wrong");
  cnt_bound_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      busy_o[0] && cfg_i[0].mode != DBF_OFF |-> cnt_ff[0] < eff_time(cfg_i[0].time_us)
      || !$stable(cfg_i[0].time_us))
    else $error("hold counter passed debounce time");

  // Entry, hold and idle checks repeated on every channel
  for (genvar g = 0; g < NCH; g++) begin : g_chk
    off_clear_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_i[g].mode == DBF_OFF |=> !busy_o[g] && dout_o[g] == $past(din_i[g]))
      else $error("off mode held or filtered the input");
    rise_hold_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_i[g].mode == DBF_STR_RISE && busy_o[g] && !tick |=> dout_o[g])
      else $error("stretch rise hold let the output drop");
    fall_hold_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_i[g].mode == DBF_STR_FALL && busy_o[g] && !tick |=> !dout_o[g])
      else $error("stretch fall hold let the output rise");
    rise_rearm_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_i[g].mode == DBF_STR_RISE && din_i[g] && !prev_ff[g] |=> cnt_ff[g] == CNT_RESET)
      else $error("rising edge did not restart the hold count");
    both_entry_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_i[g].mode == DBF_STR_BOTH && !busy_o[g] && din_i[g] != prev_ff[g]
        |=> busy_o[g] && dout_o[g] == $past(din_i[g]))
      else $error("stretch both edge not passed at once");
    dly_entry_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_i[g].mode == DBF_DLY_BOTH && !busy_o[g] && din_i[g] != prev_ff[g]
        |=> busy_o[g] && dout_o[g] == $past(din_i[g]))
      else $error("delay edge did not start a hold");
    idle_follow_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !busy_o[g] && din_i[g] == prev_ff[g] |=> dout_o[g] == $past(din_i[g]))
      else $error("idle channel did not follow its input");
    zero_clamp_a : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_i[g].mode == DBF_DLY_BOTH && busy_o[g] && tick && cfg_i[g].time_us == 16'h0000
        |=> !busy_o[g])
      else $error("zero time did not end the hold on the first tick");
  end : g_chk
endmodule // dbf_filter
`default_nettype wire

// ==== hdl/dbf_pkg.sv ====
// Behaviour
// - Each channel picks its own mode: off, stretch rise, stretch fall, stretch both, delay.
// - Each channel holds its own debounce time in microseconds, 1 to 65535.
// - Mode off passes the sampled input straight to the output.
// - Stretch rise: rising edge forces high, held for debounce time, then transparent.
// - Stretch fall: falling edge forces low, held for debounce time, then transparent.
// - Stretch both: any edge passes at once, new level held for debounce time.
// - Delay both: first edge blocks input, output keeps edge level for debounce time.
// - Delay both: at hold end output takes current input, then re-arms for any edge.
// - Eight identical channels numbered zero through seven, each with mode and time.
package dbf_pkg;
  localparam int CLK_FREQ_HZ = 10000000;
  localparam int TICK_PERIOD_US = 1;
  // Cycles per microsecond tick, derived from the clock rate
  localparam int TICK_CYCLES = (CLK_FREQ_HZ / 1000000) * TICK_PERIOD_US;
  localparam int NUM_CHANNELS = 8;
  localparam int TIME_WIDTH = 16;
  localparam logic [15:0] TIME_MIN_US = 16'h0001;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  typedef enum logic [2:0] {
    DBF_OFF = 3'b000,
    DBF_STR_RISE = 3'b001,
    DBF_STR_FALL = 3'b010,
    DBF_STR_BOTH = 3'b011,
    DBF_DLY_BOTH = 3'b100
  } dbf_mode_e;

  // Per-channel configuration
  typedef struct packed {
    dbf_mode_e mode;
    logic [TIME_WIDTH-1:0] time_us;
  } dbf_cfg_s;
endpackage : dbf_pkg

// ==== sim/dbf_field.sv ====
`timescale 1ns/1ps
`default_nettype none
// Field side of the isolated inputs; levels settle away from the sampling edge
module dbf_field (
  input wire logic ref_clk_i,
  input wire logic [7:0] lvl_i,
  output logic [7:0] din_o = 8'h00
);
  // Falling edge launch keeps the filter's rising-edge sample race free
  always_ff @(negedge ref_clk_i) begin
    din_o <= lvl_i;
  end
endmodule // dbf_field
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dbf_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] lvl = 8'h00;
  logic [7:0] din;
  logic [7:0] dout;
  logic [7:0] busy;
  logic [31:0] rng = 32'h00000044;
  dbf_cfg_s cfg [8];
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  // Clock at 10 MHz
  always #50 ref_clk_i = ~ref_clk_i;
  dbf_field i_dbf_field (.ref_clk_i(ref_clk_i), .lvl_i(lvl), .din_o(din));
  dbf_filter #(.NCH(8)) i_dbf_filter (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .cfg_i(cfg), .din_i(din), .dout_o(dout), .busy_o(busy));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Channels that must hold the level of an edge of the given direction
  function automatic logic [7:0] held(input logic rise);
    held = 8'h00;
    for (int i = 0; i < 8; i++)
      held[i] = (cfg[i].mode == DBF_STR_RISE && rise) || (cfg[i].mode == DBF_STR_FALL && !rise)
        || cfg[i].mode == DBF_STR_BOTH || cfg[i].mode == DBF_DLY_BOTH;
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One-cycle glitch away from a settled idle level; holds outlast it, others do not
  task automatic pulse(input logic v0);
    logic [7:0] h;
    h = held(!v0);
    lvl <= {8{v0}};
    repeat (40) @(negedge ref_clk_i);
    lvl <= {8{!v0}};
    @(negedge ref_clk_i);
    lvl <= {8{v0}};
    repeat (9) @(negedge ref_clk_i);
    check("dout_hold", dout, (h & {8{!v0}}) | (~h & {8{v0}}));
    // The return edge arms the opposite stretch mode too, so all four modes hold
    check("busy_hold", busy, held(1'b0) | held(1'b1));
    repeat (30) @(negedge ref_clk_i);
    check("dout_end", dout, {8{v0}});
    check("busy_end", busy, 8'h00);
  endtask
  // Hang guard well above the expected run of about 1500 cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    for (int i = 0; i < 8; i++) cfg[i] = '{mode: dbf_mode_e'(3'(i)), time_us: 16'h0002};
    repeat (12) @(negedge ref_clk_i);
    check("dout_rst", dout, 8'h00);
    check("busy_rst", busy, 8'h00);
    rst_n_i <= 1'b1;
    // Rotate modes so every channel sees every mode, times 2 or 3 us at random
    for (int r = 0; r < 8; r++) begin
      rng = xs(rng);
      for (int i = 0; i < 8; i++)
        cfg[i] = '{mode: dbf_mode_e'(3'(i + r)), time_us: 16'h0002 + 16'(rng[i])};
      pulse(1'b0);
      pulse(1'b1);
    end
    // Corner: zero time acts as the shortest hold; a level changed inside it lands at expiry
    for (int i = 0; i < 8; i++) cfg[i] = '{mode: DBF_DLY_BOTH, time_us: 16'h0000};
    lvl <= 8'h00;
    repeat (2) @(negedge ref_clk_i);
    check("dout_zero", dout, 8'h00);
    check("busy_zero", busy, 8'hff);
    lvl <= 8'hff;
    repeat (12) @(negedge ref_clk_i);
    check("dout_zero_end", dout, 8'hff);
    check("busy_zero_end", busy, 8'h00);
    for (int i = 0; i < 8; i++) cfg[i].mode = DBF_OFF;
    repeat (50) begin
      rng = xs(rng);
      lvl <= rng[7:0];
      repeat (3) @(negedge ref_clk_i);
      check("dout_off", dout, rng[7:0]);
    end
    wrap_up();
  end
endmodule // tb
`default_nettype wire
